// file: rtl/tcru_consts.svh
// register indices, field positions, reset values and vectors of the timer capture/reload unit
`ifndef TCRU_CONSTS_SVH
`define TCRU_CONSTS_SVH

// ----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define TCRU_IDX_T5        16'hfe46
`define TCRU_IDX_T6        16'hfe48
`define TCRU_IDX_CAPTURE_RELOAD_REGISTER    16'hfe4a
`define TCRU_IDX_T5CTL     16'hff46
`define TCRU_IDX_T6CTL     16'hff48
`define TCRU_IDX_TIMER_FIVE_IRQ_CONTROL      16'hff66
`define TCRU_IDX_TIMER_SIX_IRQ_CONTROL      16'hff68
`define TCRU_IDX_CRIC      16'hff6a
`define TCRU_IDX_STATUS    16'hff70
`define TCRU_IDX_MASK      16'hff72

// ----------------------------------------------------------------------------
// control fields
// ----------------------------------------------------------------------------
`define TCRU_F_RUN         0
`define TCRU_F_DOWN        1
`define TCRU_F_SRC         2
`define TCRU_F_PRE_LO      3
`define TCRU_F_PRE_HI      5
`define TCRU_F_RELOAD      6
`define TCRU_F_CLR         8
`define TCRU_F_EDGE_LO     9
`define TCRU_F_EDGE_HI     10
`define TCRU_F_CSRC_LO     11
`define TCRU_F_CSRC_HI     12
`define TCRU_T5CTL_MASK    16'h1f3f
`define TCRU_T6CTL_MASK    16'h007b

// ----------------------------------------------------------------------------
// interrupt control fields and reset values
// ----------------------------------------------------------------------------
`define TCRU_F_IR          7
`define TCRU_F_IE          6
`define TCRU_RST16         16'h0000

// ----------------------------------------------------------------------------
// interrupt vector locations and trap numbers
// ----------------------------------------------------------------------------
`define TCRU_VEC_T5        24'h000094
`define TCRU_VEC_T6        24'h000098
`define TCRU_VEC_CR        24'h00009c
`define TCRU_TRAP_T5       8'h25
`define TCRU_TRAP_T6       8'h26
`define TCRU_TRAP_CR       8'h27

`endif

// file: rtl/tcru_pkg.sv
// types shared by the timer capture/reload unit
`default_nettype none

package tcru_pkg;

  // --------------------------------------------------------------------------
  // capture edge and capture source selections
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    TCRU_EDGE_NONE = 2'h0,
    TCRU_EDGE_RISE = 2'h1,
    TCRU_EDGE_FALL = 2'h2,
    TCRU_EDGE_BOTH = 2'h3
  } tcru_edge_e;

  typedef enum logic [1:0] {
    TCRU_CSRC_PIN   = 2'h0,
    TCRU_CSRC_COUNT = 2'h1,
    TCRU_CSRC_DIR   = 2'h2,
    TCRU_CSRC_AUX   = 2'h3
  } tcru_csrc_e;

endpackage

`default_nettype wire

// file: rtl/tcru_sync.sv
// three-stage input synchroniser with agreement filter and edge pulses
`default_nettype none

module tcru_sync #(
  parameter int N = 3
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [N-1:0] async_in,
  output var  logic [N-1:0] rise,
  output var  logic [N-1:0] fall
);

  logic [N-1:0] s1_r;
  logic [N-1:0] s2_r;
  logic [N-1:0] s3_r;
  logic [N-1:0] filt_r;
  logic [N-1:0] filt_nxt;

  // --------------------------------------------------------------------------
  // per input: a change is accepted once stages two and three agree
  // --------------------------------------------------------------------------
  for (genvar i = 0; i < N; i++) begin : g_bit
    assign filt_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : filt_r[i];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_r   <= '0;
      s2_r   <= '0;
      s3_r   <= '0;
      filt_r <= '0;
      rise   <= '0;
      fall   <= '0;
    end else begin
      s1_r   <= async_in;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      filt_r <= filt_nxt;
      rise   <= filt_nxt & ~filt_r;
      fall   <= ~filt_nxt & filt_r;
    end
  end

endmodule

`default_nettype wire

// file: rtl/tcru_top.sv
// timer capture/reload unit: timers five and six, capture/reload register, AHB-Lite slave
//
// The AHB-Lite interface to the registers is this design's own decision.
`include "tcru_consts.svh"
`default_nettype none

module tcru_top
  import tcru_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  input  wire logic        capture_input_pin,
  input  wire logic        aux_timer_count_input,
  input  wire logic        aux_timer_direction_input,
  output var  logic        timer_six_latch,
  output var  logic        irq,
  output var  logic [23:0] irq_vector,
  output var  logic [7:0]  irq_trap
);

  // --------------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------------
  logic         dph_r;
  logic         dph_wr_r;
  logic [31:0]  dph_addr_r;
  logic         accept;
  logic         wr_en;
  logic [31:0]  rd_nxt;
  logic [W-1:0] t5_r;
  logic [W-1:0] t6_r;
  logic [W-1:0] capture_reload_register_r;
  logic [15:0]  t5ctl_r;
  logic [15:0]  t6ctl_r;
  logic [15:0]  pre_r;
  logic [2:0]   req_r;
  logic [2:0]   en_r;
  logic [2:0]   req_set;
  logic [2:0]   req_clr;
  logic [2:0]   pin_rise;
  logic [2:0]   pin_fall;
  logic         t5_step;
  logic         t6_step;
  logic         t6_flow;
  logic         t5_flow;
  logic         cap_fire;
  logic         pin_trig;
  logic         cnt_trig;
  logic         dir_trig;
  tcru_edge_e   cap_edge;
  tcru_csrc_e   cap_src;

  localparam logic [15:0] IC_IDX [3] = '{`TCRU_IDX_TIMER_FIVE_IRQ_CONTROL, `TCRU_IDX_TIMER_SIX_IRQ_CONTROL, `TCRU_IDX_CRIC};

  function automatic logic hit(input logic [31:0] a, input logic [15:0] idx);
    hit = (a == {14'h0000, idx, 2'b00});
  endfunction

  function automatic logic tick(input logic [15:0] cnt, input logic [2:0] n);
    logic [15:0] m;
    m    = (16'h0001 << n) - 16'h0001;
    tick = &(cnt | ~m);
  endfunction

  function automatic logic sel_edge(input tcru_edge_e e, input logic r, input logic f);
    sel_edge = ((e == TCRU_EDGE_RISE) || (e == TCRU_EDGE_BOTH)) && r ||
               ((e == TCRU_EDGE_FALL) || (e == TCRU_EDGE_BOTH)) && f;
  endfunction

  // --------------------------------------------------------------------------
  // input pins
  // --------------------------------------------------------------------------
  tcru_sync #(
    .N (3)
  ) u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in ({aux_timer_direction_input, aux_timer_count_input, capture_input_pin}),
    .rise     (pin_rise),
    .fall     (pin_fall)
  );

  // --------------------------------------------------------------------------
  // AHB-Lite slave: one wait state, then the data phase completes
  // --------------------------------------------------------------------------
  // a new address phase is refused while a data phase is pending
  assign accept = hsel && hready && htrans[1] && !dph_r;
  assign wr_en  = dph_r && dph_wr_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dph_r      <= 1'b0;
      dph_wr_r   <= 1'b0;
      dph_addr_r <= '0;
    end else begin
      dph_r <= accept;
      if (accept) begin
        dph_wr_r   <= hwrite;
        dph_addr_r <= haddr;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= '0;
    end else begin
      hreadyout <= dph_r ? 1'b1 : !accept;
      hresp     <= 1'b0;
      if (dph_r && !dph_wr_r) begin
        hrdata <= rd_nxt;
      end
    end
  end

  always_comb begin
    rd_nxt = '0;
    if (hit(dph_addr_r, `TCRU_IDX_T5))          rd_nxt[W-1:0] = t5_r;
    else if (hit(dph_addr_r, `TCRU_IDX_T6))     rd_nxt[W-1:0] = t6_r;
    else if (hit(dph_addr_r, `TCRU_IDX_CAPTURE_RELOAD_REGISTER)) rd_nxt[W-1:0] = capture_reload_register_r;
    else if (hit(dph_addr_r, `TCRU_IDX_T5CTL))  rd_nxt[15:0]  = t5ctl_r;
    else if (hit(dph_addr_r, `TCRU_IDX_T6CTL))  rd_nxt[15:0]  = t6ctl_r;
    else if (hit(dph_addr_r, `TCRU_IDX_STATUS)) rd_nxt[2:0]   = req_r;
    else if (hit(dph_addr_r, `TCRU_IDX_MASK))   rd_nxt[2:0]   = en_r;
    else begin
      for (int i = 0; i < 3; i++) begin
        if (hit(dph_addr_r, IC_IDX[i])) begin
          rd_nxt[`TCRU_F_IR] = req_r[i];
          rd_nxt[`TCRU_F_IE] = en_r[i];
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // control registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      t5ctl_r <= `TCRU_RST16;
      t6ctl_r <= `TCRU_RST16;
    end else begin
      if (wr_en && hit(dph_addr_r, `TCRU_IDX_T5CTL)) t5ctl_r <= hwdata[15:0] & `TCRU_T5CTL_MASK;
      if (wr_en && hit(dph_addr_r, `TCRU_IDX_T6CTL)) t6ctl_r <= hwdata[15:0] & `TCRU_T6CTL_MASK;
    end
  end

  // --------------------------------------------------------------------------
  // prescaler and count steps
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) pre_r <= '0;
    else     pre_r <= pre_r + 16'h0001;
  end

  assign t6_step = t6ctl_r[`TCRU_F_RUN] && tick(pre_r, t6ctl_r[`TCRU_F_PRE_HI:`TCRU_F_PRE_LO]);
  assign t6_flow = t6_step && (t6ctl_r[`TCRU_F_DOWN] ? (t6_r == '0) : (&t6_r));
  assign t5_step = t5ctl_r[`TCRU_F_RUN] &&
                   (t5ctl_r[`TCRU_F_SRC] ? t6_flow
                                        : tick(pre_r, t5ctl_r[`TCRU_F_PRE_HI:`TCRU_F_PRE_LO]));
  assign t5_flow = t5_step && (t5ctl_r[`TCRU_F_DOWN] ? (t5_r == '0) : (&t5_r));

  // --------------------------------------------------------------------------
  // capture trigger
  // --------------------------------------------------------------------------
  assign cap_edge = tcru_edge_e'(t5ctl_r[`TCRU_F_EDGE_HI:`TCRU_F_EDGE_LO]);
  assign cap_src  = tcru_csrc_e'(t5ctl_r[`TCRU_F_CSRC_HI:`TCRU_F_CSRC_LO]);
  assign pin_trig = sel_edge(cap_edge, pin_rise[0], pin_fall[0]);
  assign cnt_trig = sel_edge(cap_edge, pin_rise[1], pin_fall[1]);
  assign dir_trig = sel_edge(cap_edge, pin_rise[2], pin_fall[2]);

  always_comb begin
    unique case (cap_src)
      TCRU_CSRC_PIN:   cap_fire = pin_trig;
      TCRU_CSRC_COUNT: cap_fire = cnt_trig;
      TCRU_CSRC_DIR:   cap_fire = dir_trig;
      TCRU_CSRC_AUX:   cap_fire = cnt_trig || dir_trig;
    endcase
  end

  // --------------------------------------------------------------------------
  // timer five, timer six, capture/reload register
  // --------------------------------------------------------------------------
  // a bus write wins over clear, reload and counting
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      t5_r <= '0;
    end else if (wr_en && hit(dph_addr_r, `TCRU_IDX_T5)) begin
      t5_r <= hwdata[W-1:0];
    end else if (cap_fire && t5ctl_r[`TCRU_F_CLR]) begin
      t5_r <= '0;
    end else if (t5_step) begin
      t5_r <= t5ctl_r[`TCRU_F_DOWN] ? t5_r - 1'b1 : t5_r + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      t6_r <= '0;
    end else if (wr_en && hit(dph_addr_r, `TCRU_IDX_T6)) begin
      t6_r <= hwdata[W-1:0];
    end else if (t6_flow && t6ctl_r[`TCRU_F_RELOAD]) begin
      t6_r <= capture_reload_register_r;
    end else if (t6_step) begin
      t6_r <= t6ctl_r[`TCRU_F_DOWN] ? t6_r - 1'b1 : t6_r + 1'b1;
    end
  end

  // a capture wins over a bus write to capture/reload
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      capture_reload_register_r <= '0;
    end else if (cap_fire) begin
      capture_reload_register_r <= t5_r;
    end else if (wr_en && hit(dph_addr_r, `TCRU_IDX_CAPTURE_RELOAD_REGISTER)) begin
      capture_reload_register_r <= hwdata[W-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst)          timer_six_latch <= 1'b0;
    else if (t6_flow) timer_six_latch <= !timer_six_latch;
  end

  // --------------------------------------------------------------------------
  // interrupt nodes: request set wins over clear
  // --------------------------------------------------------------------------
  assign req_set = {cap_fire, t6_flow, t5_flow};

  for (genvar i = 0; i < 3; i++) begin : g_node
    logic rq_r;
    logic ie_r;

    assign req_clr[i] = wr_en && (
                        (hit(dph_addr_r, IC_IDX[i]) && hwdata[`TCRU_F_IR]) ||
                        (hit(dph_addr_r, `TCRU_IDX_STATUS) && hwdata[i]));

    // enable storage is shared by the irq control word and the mask
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        rq_r <= 1'b0;
        ie_r <= 1'b0;
      end else begin
        rq_r <= req_set[i] || (rq_r && !req_clr[i]);
        if (wr_en && hit(dph_addr_r, IC_IDX[i])) ie_r <= hwdata[`TCRU_F_IE];
        else if (wr_en && hit(dph_addr_r, `TCRU_IDX_MASK)) ie_r <= hwdata[i];
      end
    end

    assign req_r[i] = rq_r;
    assign en_r[i]  = ie_r;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq        <= 1'b0;
      irq_vector <= '0;
      irq_trap   <= '0;
    end else begin
      irq <= |(req_r & en_r);
      if (req_r[0] && en_r[0]) begin
        irq_vector <= `TCRU_VEC_T5;
        irq_trap   <= `TCRU_TRAP_T5;
      end else if (req_r[1] && en_r[1]) begin
        irq_vector <= `TCRU_VEC_T6;
        irq_trap   <= `TCRU_TRAP_T6;
      end else if (req_r[2] && en_r[2]) begin
        irq_vector <= `TCRU_VEC_CR;
        irq_trap   <= `TCRU_TRAP_CR;
      end else begin
        irq_vector <= '0;
        irq_trap   <= '0;
      end
    end
  end

endmodule

`default_nettype wire

// file: verif/tcru_pins.sv
// pin-side model driving the capture pin and the aux timer inputs
`default_nettype none

module tcru_pins (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [2:0] want,
  input  wire logic [3:0] lag,
  output var  logic [2:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_r;

  // a requested level reaches the pins on the lag+1-th clock edge that sees it differ
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 4'h0;
      pins  <= 3'h0;
    end else if (want == pins) begin
      cnt_r <= 4'h0;
    end else if (cnt_r >= lag) begin
      cnt_r <= 4'h0;
      pins  <= want;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule

`default_nettype wire

// file: verif/tcru_properties.sv
// concurrent checks on the ports of the timer capture/reload unit
`include "tcru_consts.svh"
`default_nettype none

module tcru_properties (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        capture_input_pin,
  input wire logic        aux_timer_count_input,
  input wire logic        aux_timer_direction_input,
  input wire logic        timer_six_latch,
  input wire logic        irq,
  input wire logic [23:0] irq_vector,
  input wire logic [7:0]  irq_trap
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rd_p1_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ---------------------------------------------------------------------------
  // read accepted last edge
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      rd_p1_r <= 1'b0;
    else
      rd_p1_r <= hsel && hready && htrans[1] && !hwrite && hreadyout;
  end

  sequence s_take;
    hsel && hready && htrans[1] && hreadyout;
  endsequence
  sequence s_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  property p_ready_walk;   s_take |=> s_wait; endproperty
  property p_ready_single; !hreadyout |=> hreadyout; endproperty
  property p_hresp_okay;   hresp == 1'b0; endproperty
  property p_rdata_hold;   $changed(hrdata) |-> $past(rd_p1_r); endproperty
  property p_reset_quiet;
    $fell(rst) |-> !irq && !timer_six_latch && hrdata == 32'h0 && irq_trap == 8'h0;
  endproperty
  property p_vec_t5; irq_trap == 8'h25 |-> irq_vector == 24'h000094; endproperty
  property p_vec_t6; irq_trap == 8'h26 |-> irq_vector == 24'h000098; endproperty
  property p_vec_cr; irq_trap == 8'h27 |-> irq_vector == 24'h00009c; endproperty
  property p_trap_set; irq_trap inside {8'h0, 8'h25, 8'h26, 8'h27}; endproperty
  property p_irq_trap; irq == (irq_trap != 8'h0); endproperty

  a_ready_walk: assert property (p_ready_walk)
    else $error("bus answer not two cycles");
  a_ready_single: assert property (p_ready_single)
    else $error("wait state longer than one cycle");
  a_hresp_okay: assert property (p_hresp_okay)
    else $error("response not okay");
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without a read");
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs not quiet after reset");
  a_vec_t5: assert property (p_vec_t5)
    else $error("timer five vector wrong");
  a_vec_t6: assert property (p_vec_t6)
    else $error("timer six vector wrong");
  a_vec_cr: assert property (p_vec_cr)
    else $error("capture vector wrong");
  a_trap_set: assert property (p_trap_set)
    else $error("unknown trap number");
  a_irq_trap: assert property (p_irq_trap)
    else $error("interrupt level and trap number disagree");
endmodule

bind tcru_top tcru_properties i_props (
  .clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
  .hreadyout, .hresp, .capture_input_pin, .aux_timer_count_input,
  .aux_timer_direction_input, .timer_six_latch, .irq, .irq_vector, .irq_trap
);

`default_nettype wire

// file: verif/tcru_top_tb.sv
// self-checking testbench of the timer capture/reload unit
`include "tcru_consts.svh"
`default_nettype none

module tcru_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, hsel, hwrite, hreadyout, hresp, latch, irq;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize, want, pins;
  logic [3:0]  lag;
  logic [23:0] vec;
  logic [7:0]  trap;
  int          fail_count, checked;

  tcru_top #(.W(16)) i_dut (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .capture_input_pin(pins[0]),
    .aux_timer_count_input(pins[1]), .aux_timer_direction_input(pins[2]),
    .timer_six_latch(latch), .irq(irq), .irq_vector(vec), .irq_trap(trap)
  );
  tcru_pins i_pins (.clk(clk), .rst(rst), .want(want), .lag(lag), .pins(pins));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wait_rdy();
    do begin
      @(negedge clk);
    end while (hreadyout !== 1'b1);
    @(posedge clk);
  endtask
  task automatic bus(input logic w, input logic [15:0] i, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {14'h0, i, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
    hsel <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] i, input logic [31:0] d);
    bus(1'b1, i, d);
  endtask
  task automatic rc(input logic [15:0] i, input logic [31:0] e);
    bus(1'b0, i, 32'h0);
    chk(r, e);
  endtask
  task automatic irq_is(input logic q, input logic [7:0] t, input logic [23:0] v);
    repeat (3) @(negedge clk);
    chk({31'h0, irq}, {31'h0, q});
    chk({24'h0, trap}, {24'h0, t});
    chk({8'h0, vec}, {8'h0, v});
  endtask

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    logic [15:0] idx [6] = '{`TCRU_IDX_T5, `TCRU_IDX_T6, `TCRU_IDX_T5CTL,
                             `TCRU_IDX_T6CTL, `TCRU_IDX_TIMER_FIVE_IRQ_CONTROL, `TCRU_IDX_TIMER_SIX_IRQ_CONTROL};
    foreach (idx[i]) rc(idx[i], 32'h0);
    irq_is(1'b0, 8'h0, 24'h0);
    wr(16'h0100, 32'h5a5a);
    rc(16'h0100, 32'h0);
    wr(`TCRU_IDX_T5, 32'hffff1234);
    rc(`TCRU_IDX_T5, 32'h1234);
    $display("reset test done");
  endtask
  task automatic t_rerst();
    logic [15:0] idx [7] = '{`TCRU_IDX_T5, `TCRU_IDX_T6, `TCRU_IDX_CAPTURE_RELOAD_REGISTER, `TCRU_IDX_T5CTL,
                             `TCRU_IDX_T6CTL, `TCRU_IDX_TIMER_FIVE_IRQ_CONTROL, `TCRU_IDX_TIMER_SIX_IRQ_CONTROL};
    want <= 3'h0;
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    foreach (idx[i]) rc(idx[i], 32'h0);
    irq_is(1'b0, 8'h0, 24'h0);
    chk({31'h0, latch}, 32'h0);
    $display("mid-run reset test done");
  endtask
  task automatic t_down();
    wr(`TCRU_IDX_T5CTL, 32'h7);
    wr(`TCRU_IDX_CAPTURE_RELOAD_REGISTER, 32'h80);
    wr(`TCRU_IDX_T6, 32'h2);
    wr(`TCRU_IDX_T6CTL, 32'h4b);
    repeat (20) @(posedge clk);
    wr(`TCRU_IDX_T6CTL, 32'h4a);
    bus(1'b0, `TCRU_IDX_T6, 32'h0);
    chk({31'h0, r >= 32'h70 && r < 32'h80}, 32'h1);
    rc(`TCRU_IDX_T5, 32'hffff);
    rc(`TCRU_IDX_STATUS, 32'h3);
    chk({31'h0, latch}, 32'h1);
    $display("down count test done");
  endtask
  task automatic t_wrap();
    wr(`TCRU_IDX_T5, 32'hffff);
    wr(`TCRU_IDX_T5CTL, 32'h5);
    wr(`TCRU_IDX_TIMER_FIVE_IRQ_CONTROL, 32'h40);
    wr(`TCRU_IDX_CAPTURE_RELOAD_REGISTER, 32'h100);
    wr(`TCRU_IDX_T6, 32'hfff0);
    wr(`TCRU_IDX_T6CTL, 32'h41);
    repeat (40) @(posedge clk);
    wr(`TCRU_IDX_T6CTL, 32'h40);
    bus(1'b0, `TCRU_IDX_T6, 32'h0);
    chk({31'h0, r >= 32'h100 && r < 32'h140}, 32'h1);
    rc(`TCRU_IDX_T5, 32'h0);
    chk({31'h0, latch}, 32'h1);
    irq_is(1'b1, 8'h25, 24'h000094);
    wr(`TCRU_IDX_TIMER_FIVE_IRQ_CONTROL, 32'hc0);
    rc(`TCRU_IDX_TIMER_FIVE_IRQ_CONTROL, 32'h40);
    wr(`TCRU_IDX_TIMER_SIX_IRQ_CONTROL, 32'h40);
    irq_is(1'b1, 8'h26, 24'h000098);
    rc(`TCRU_IDX_TIMER_SIX_IRQ_CONTROL, 32'hc0);
    $display("reload test done");
  endtask
  task automatic t_capture();
    wr(`TCRU_IDX_STATUS, 32'h7);
    wr(`TCRU_IDX_MASK, 32'h0);
    wr(`TCRU_IDX_T5, 32'h0abc);
    wr(`TCRU_IDX_T5CTL, 32'h300);
    lag <= 4'h9;
    want[0] <= 1'b1;
    repeat (30) @(posedge clk);
    rc(`TCRU_IDX_CAPTURE_RELOAD_REGISTER, 32'h0abc);
    rc(`TCRU_IDX_T5, 32'h0);
    rc(`TCRU_IDX_STATUS, 32'h4);
    irq_is(1'b0, 8'h0, 24'h0);
    wr(`TCRU_IDX_MASK, 32'h4);
    irq_is(1'b1, 8'h27, 24'h00009c);
    wr(`TCRU_IDX_T5, 32'h0def);
    want[0] <= 1'b0;
    repeat (30) @(posedge clk);
    rc(`TCRU_IDX_CAPTURE_RELOAD_REGISTER, 32'h0abc);
    wr(`TCRU_IDX_STATUS, 32'h4);
    irq_is(1'b0, 8'h0, 24'h0);
    $display("capture test done");
  endtask
  task automatic t_aux();
    for (int k = 1; k < 4; k++) begin
      wr(`TCRU_IDX_T5, 32'h50 + k);
      wr(`TCRU_IDX_T5CTL, 32'h0600 | (k << 11));
      lag <= 4'h0;
      want[k == 1 ? 1 : 2] <= !want[k == 1 ? 1 : 2];
      repeat (12) @(posedge clk);
      rc(`TCRU_IDX_CAPTURE_RELOAD_REGISTER, 32'h50 + k);
    end
    $display("aux capture test done");
  endtask

  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    rst    = 1'b1;
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
    want   = 3'h0;
    lag    = 4'h0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_wrap();
    t_capture();
    t_aux();
    t_rerst();
    t_down();
    finish_test();
  end

  initial begin
    #50us;
    fail_count++;
    finish_test();
  end
endmodule

`default_nettype wire
